// >>> verilog/dirt_pkg.sv
package dirt_pkg;

    // ==========================================
    // Register word indices, byte address = index * 4
    localparam logic [3:0] IDX_BYTE_CTRL  = 4'h0;
    localparam logic [3:0] IDX_SHARED     = 4'h1;
    localparam logic [3:0] IDX_WIDE_CTRL  = 4'h2;
    localparam logic [3:0] IDX_BYTE_LOW   = 4'h4;
    localparam logic [3:0] IDX_BYTE_HIGH  = 4'h5;
    localparam logic [3:0] IDX_WORD_LOW   = 4'h6;
    localparam logic [3:0] IDX_WORD_HIGH  = 4'h7;
    localparam logic [3:0] IDX_PORT_DATA  = 4'h8;
    localparam logic [3:0] IDX_BYTE_COUNT = 4'h9;
    localparam logic [3:0] IDX_WORD_COUNT = 4'hA;

    // ==========================================
    // Counter control fields (byte and wide alike)
    localparam int BIT_RUN     = 7;
    localparam int BIT_SINGLE  = 6;
    localparam int BIT_TOUT    = 5;
    localparam int CLK_HI      = 4;
    localparam int CLK_LO      = 3;
    localparam int BIT_CAP_IE  = 2;
    localparam int BIT_TOUT_IE = 1;
    localparam int BIT_PIN_SEL = 0;

    // ==========================================
    // Shared control fields
    localparam int BIT_DEMOD     = 7;
    localparam int BIT_SHARED_PIN = 6;
    localparam int COMB_HI       = 5;
    localparam int COMB_LO       = 4;
    localparam int FORCE_HI      = 3;
    localparam int FORCE_LO      = 2;
    localparam int BIT_BYTE_INIT = 1;
    localparam int BIT_WORD_INIT = 0;

    // ==========================================
    // Reset values and fields kept over stop-mode recovery
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam logic [7:0] SHARED_RST   = 8'h00;
    localparam logic [7:0] HOLD_RST     = 8'h00;
    localparam logic [2:0] PORT_RST     = 3'h0;
    localparam logic [7:0] CTRL_KEEP    = 8'h1E;
    localparam logic [7:0] SHARED_KEEP  = 8'h30;

    // ==========================================
    // Encodings
    localparam logic [1:0] COMB_AND   = 2'h0;
    localparam logic [1:0] COMB_OR    = 2'h1;
    localparam logic [1:0] COMB_NOR   = 2'h2;
    localparam logic [1:0] COMB_NAND  = 2'h3;
    localparam logic [1:0] EDGE_FALL  = 2'h0;
    localparam logic [1:0] EDGE_RISE  = 2'h1;
    localparam logic [1:0] EDGE_BOTH  = 2'h2;
    localparam logic [1:0] FORCE_LOW  = 2'h2;
    localparam logic [1:0] FORCE_HIGH = 2'h3;
    localparam logic [1:0] DIV_BY_8   = 2'h3;

    typedef enum logic [1:0] {
        BC_IDLE  = 2'b00,
        BC_FIRST = 2'b01,
        BC_RUN   = 2'b11
    } dirt_bphase_e;

endpackage

// >>> verilog/dirt_prescaler.sv
`timescale 1ns/100ps
module dirt_prescaler
    import dirt_pkg::*;
#(
    parameter int W = 3
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [1:0]   sel_i,
    output wire logic         tick_o
);

    logic [W-1:0] div_q;
    wire  [W-1:0] mask = W'((4'h1 << sel_i) - 4'h1);

    // Free running so that both dividers stay in phase
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + W'(1);
        end
    end

    assign tick_o = (div_q & mask) == mask;

endmodule

// >>> verilog/dirt_timer.sv
`timescale 1ns/100ps
module dirt_timer
    import dirt_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [5:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output wire logic [31:0] avs_readdata_o,
    output wire logic        avs_waitrequest_o,
    input  wire logic        stop_recover_i,
    input  wire logic        demod_input_pin_a_i,
    input  wire logic        demod_input_pin_b_i,
    output wire logic        byte_output_pin_o,
    output wire logic        word_output_pin_o,
    output wire logic        shared_output_pin_o,
    output wire logic        byte_timeout_irq_o,
    output wire logic        word_timeout_irq_o
);

    // ==========================================
    // Reset release
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ==========================================
    // State
    logic [31:0]  readdata_q;
    logic         wait_q;
    logic [7:0]   byte_cfg_q, shared_q, wide_cfg_q;
    logic [7:0]   blo_q, bhi_q, wlo_q, whi_q;
    logic [2:0]   port_q;
    dirt_bphase_e bstate_q, bstate_d;
    logic [7:0]   bcnt_q, bcnt_d;
    logic         bout_q, bout_d;
    logic         bflag_q;
    logic         wrun_q, wrun_d;
    logic [15:0]  wcnt_q, wcnt_d;
    logic         wout_q, wout_d;
    logic         wflag_q;
    logic         pin_prev_q;
    logic         byte_pin_q, word_pin_q, shared_pin_q;
    logic         byte_irq_q, word_irq_q;
    logic [7:0]   rd_val;

    // ==========================================
    // Bus decode
    wire [3:0] idx       = avs_address_i[5:2];
    wire       aligned   = avs_address_i[1:0] == 2'b00;
    wire       req       = avs_read_i | avs_write_i;
    wire       wr_go     = avs_write_i & ~wait_q & avs_byteenable_i[0] & aligned;
    wire [7:0] wd        = avs_writedata_i[7:0];
    wire       wr_bctrl  = wr_go & (idx == IDX_BYTE_CTRL);
    wire       wr_shared = wr_go & (idx == IDX_SHARED);
    wire       wr_wctrl  = wr_go & (idx == IDX_WIDE_CTRL);
    wire       smr       = stop_recover_i;

    // ==========================================
    // Dividers and event decode
    wire byte_tick;
    wire word_tick;

    dirt_prescaler #(.W(3)) u_byte_div (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .sel_i   (byte_cfg_q[CLK_HI:CLK_LO]),
        .tick_o  (byte_tick)
    );

    dirt_prescaler #(.W(3)) u_word_div (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .sel_i   (wide_cfg_q[CLK_HI:CLK_LO]),
        .tick_o  (word_tick)
    );

    wire demod      = shared_q[BIT_DEMOD];
    wire [1:0] comb = shared_q[COMB_HI:COMB_LO];
    wire [1:0] frc  = shared_q[FORCE_HI:FORCE_LO];
    wire bstart     = wr_bctrl & wd[BIT_RUN] & (bstate_q == BC_IDLE);
    wire wstart     = wr_wctrl & wd[BIT_RUN] & ~wrun_q;
    wire byte_term  = (bstate_q != BC_IDLE) & byte_tick & (bcnt_q == 8'h01);
    wire word_term  = wrun_q & word_tick & (wcnt_q == 16'h0001);
    // Flag only on single pass or after the first half period
    wire byte_set   = ~smr & ~bstart & ~(wr_bctrl & ~wd[BIT_RUN]) & byte_term
                      & (byte_cfg_q[BIT_SINGLE] | (bstate_q == BC_RUN));
    wire demod_pin  = shared_q[BIT_SHARED_PIN] ? demod_input_pin_b_i : demod_input_pin_a_i;
    wire rise       = demod_pin & ~pin_prev_q;
    wire fall       = ~demod_pin & pin_prev_q;
    wire edge_hit   = (comb == EDGE_FALL) ? fall :
                      (comb == EDGE_RISE) ? rise :
                      (comb == EDGE_BOTH) ? (rise | fall) : 1'b0;
    wire wedge      = demod & ~wide_cfg_q[BIT_SINGLE] & edge_hit;
    wire word_set   = ~smr & ~wstart & ~(wr_wctrl & ~wd[BIT_RUN]) & wrun_q & ~wedge & word_term;
    wire word_level = frc[1] ? frc[0] : (wrun_q ? wout_q : ~shared_q[BIT_WORD_INIT]);
    wire combined   = (comb == COMB_AND) ? (bout_q & word_level) :
                      (comb == COMB_OR)  ? (bout_q | word_level) :
                      (comb == COMB_NOR) ? ~(bout_q | word_level) : ~(bout_q & word_level);

    // ==========================================
    // Byte counter
    always_comb begin
        bstate_d = bstate_q;
        bcnt_d   = bcnt_q;
        bout_d   = bout_q;
        if (smr) begin
            bstate_d = BC_IDLE;
        end else if (bstart) begin
            bout_d   = shared_q[BIT_BYTE_INIT];
            bcnt_d   = shared_q[BIT_BYTE_INIT] ? bhi_q : blo_q;
            bstate_d = wd[BIT_SINGLE] ? BC_RUN : BC_FIRST;
        end else if (wr_bctrl & ~wd[BIT_RUN]) begin
            bstate_d = BC_IDLE;
        end else if (byte_term) begin
            bout_d = ~bout_q;
            if (byte_cfg_q[BIT_SINGLE]) begin
                bcnt_d   = 8'h00;
                bstate_d = BC_IDLE;
            end else begin
                bcnt_d   = bout_q ? blo_q : bhi_q;
                bstate_d = BC_RUN;
            end
        end else if ((bstate_q != BC_IDLE) & byte_tick) begin
            bcnt_d = bcnt_q - 8'h01;
        end
    end

    // ==========================================
    // Word counter
    always_comb begin
        wrun_d = wrun_q;
        wcnt_d = wcnt_q;
        wout_d = wout_q;
        if (smr) begin
            wrun_d = 1'b0;
        end else if (wstart) begin
            wrun_d = 1'b1;
            wcnt_d = {whi_q, wlo_q};
            wout_d = shared_q[BIT_WORD_INIT];
        end else if (wr_wctrl & ~wd[BIT_RUN]) begin
            wrun_d = 1'b0;
        end else if (wrun_q & wedge) begin
            wcnt_d = {whi_q, wlo_q};
        end else if (word_term) begin
            wout_d = demod ? wout_q : ~wout_q;
            if (~demod & wide_cfg_q[BIT_SINGLE]) begin
                wrun_d = 1'b0;
                wcnt_d = 16'h0000;
            end else begin
                wcnt_d = {whi_q, wlo_q};
            end
        end else if (wrun_q & word_tick) begin
            wcnt_d = wcnt_q - 16'h0001;
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            byte_cfg_q <= CTRL_RST;
            shared_q   <= SHARED_RST;
            wide_cfg_q <= CTRL_RST;
        end else if (smr) begin
            byte_cfg_q <= byte_cfg_q & CTRL_KEEP;
            shared_q   <= shared_q & SHARED_KEEP;
            wide_cfg_q <= wide_cfg_q & CTRL_KEEP;
        end else begin
            byte_cfg_q <= wr_bctrl ? wd : byte_cfg_q;
            shared_q   <= wr_shared ? wd : shared_q;
            wide_cfg_q <= wr_wctrl ? wd : wide_cfg_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            blo_q  <= HOLD_RST;
            bhi_q  <= HOLD_RST;
            wlo_q  <= HOLD_RST;
            whi_q  <= HOLD_RST;
            port_q <= PORT_RST;
        end else begin
            blo_q  <= (wr_go & (idx == IDX_BYTE_LOW)) ? wd : blo_q;
            bhi_q  <= (wr_go & (idx == IDX_BYTE_HIGH)) ? wd : bhi_q;
            wlo_q  <= (wr_go & (idx == IDX_WORD_LOW)) ? wd : wlo_q;
            whi_q  <= (wr_go & (idx == IDX_WORD_HIGH)) ? wd : whi_q;
            port_q <= (wr_go & (idx == IDX_PORT_DATA)) ? wd[2:0] : port_q;
        end
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bstate_q   <= BC_IDLE;
            bcnt_q     <= 8'h00;
            bout_q     <= 1'b0;
            bflag_q    <= 1'b0;
            wrun_q     <= 1'b0;
            wcnt_q     <= 16'h0000;
            wout_q     <= 1'b0;
            wflag_q    <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            bstate_q   <= bstate_d;
            bcnt_q     <= bcnt_d;
            bout_q     <= bout_d;
            bflag_q    <= ~smr & (byte_set | (bflag_q & ~(wr_bctrl & wd[BIT_TOUT])));
            wrun_q     <= wrun_d;
            wcnt_q     <= wcnt_d;
            wout_q     <= wout_d;
            wflag_q    <= ~smr & (word_set | (wflag_q & ~(wr_wctrl & wd[BIT_TOUT])));
            pin_prev_q <= demod_pin;
        end
    end

    // ==========================================
    // Pins and interrupt requests
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            byte_pin_q   <= 1'b0;
            word_pin_q   <= 1'b0;
            shared_pin_q <= 1'b0;
            byte_irq_q   <= 1'b0;
            word_irq_q   <= 1'b0;
        end else begin
            byte_pin_q   <= byte_cfg_q[BIT_PIN_SEL] ? bout_q : port_q[0];
            word_pin_q   <= wide_cfg_q[BIT_PIN_SEL] ? word_level : port_q[1];
            shared_pin_q <= (~demod & shared_q[BIT_SHARED_PIN]) ? combined : port_q[2];
            byte_irq_q   <= bflag_q & byte_cfg_q[BIT_TOUT_IE];
            word_irq_q   <= wflag_q & wide_cfg_q[BIT_TOUT_IE];
        end
    end

    // ==========================================
    // Register read and bus answer
    always_comb begin
        if (!aligned) begin
            rd_val = 8'h00;
        end else if (idx == IDX_BYTE_CTRL) begin
            rd_val = {bstate_q != BC_IDLE, byte_cfg_q[6], bflag_q, byte_cfg_q[4:0]};
        end else if (idx == IDX_SHARED) begin
            rd_val = shared_q;
        end else if (idx == IDX_WIDE_CTRL) begin
            rd_val = {wrun_q, wide_cfg_q[6], wflag_q, wide_cfg_q[4:0]};
        end else if (idx == IDX_BYTE_LOW) begin
            rd_val = blo_q;
        end else if (idx == IDX_BYTE_HIGH) begin
            rd_val = bhi_q;
        end else if (idx == IDX_WORD_LOW) begin
            rd_val = wlo_q;
        end else if (idx == IDX_WORD_HIGH) begin
            rd_val = whi_q;
        end else if (idx == IDX_PORT_DATA) begin
            rd_val = {5'h00, port_q};
        end else if (idx == IDX_BYTE_COUNT) begin
            rd_val = bcnt_q;
        end else if (idx == IDX_WORD_COUNT) begin
            rd_val = wcnt_q[7:0];
        end else begin
            rd_val = 8'h00;
        end
    end

    // One wait cycle: data latched at the first edge, released at the second
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wait_q     <= 1'b1;
            readdata_q <= 32'h0000_0000;
        end else begin
            wait_q     <= ~(req & wait_q);
            readdata_q <= (avs_read_i & wait_q) ? {24'h00_0000, rd_val} : readdata_q;
        end
    end

    assign avs_readdata_o      = readdata_q;
    assign avs_waitrequest_o   = wait_q;
    assign byte_output_pin_o   = byte_pin_q;
    assign word_output_pin_o   = word_pin_q;
    assign shared_output_pin_o = shared_pin_q;
    assign byte_timeout_irq_o  = byte_irq_q;
    assign word_timeout_irq_o  = word_irq_q;

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence byte_start_s;
        bstart & ~smr;
    endsequence
    sequence byte_loaded_s;
        bout_q == $past(shared_q[BIT_BYTE_INIT])
            && bcnt_q == ($past(shared_q[BIT_BYTE_INIT]) ? $past(bhi_q) : $past(blo_q));
    endsequence
    sequence word_start_s;
        wstart & ~smr;
    endsequence
    sequence word_loaded_s;
        wrun_q && wcnt_q == {$past(whi_q), $past(wlo_q)} && wout_q == $past(shared_q[BIT_WORD_INIT]);
    endsequence

    demod_pin_port_a: assert property (demod |=> shared_pin_q == $past(port_q[2]))
        else $error("shared pin not port data in demodulation");
    combine_nand_a: assert property (~demod & shared_q[BIT_SHARED_PIN] & comb == COMB_NAND
        |=> shared_pin_q == ~($past(bout_q) & $past(word_level)))
        else $error("nand combine wrong");
    word_enable_a: assert property (word_start_s |=> word_loaded_s)
        else $error("word counter start load wrong");
    word_single_stop_a: assert property (word_term & ~demod & wide_cfg_q[BIT_SINGLE] & ~wr_wctrl & ~smr
        |=> ~wrun_q)
        else $error("single pass word counter did not stop");
    edge_ignored_a: assert property (wrun_q & demod & wide_cfg_q[BIT_SINGLE] & ~word_tick & ~wr_wctrl & ~smr
        |=> $stable(wcnt_q))
        else $error("word counter reacted to ignored edge");
    div_eight_a: assert property (word_tick & wide_cfg_q[CLK_HI:CLK_LO] == DIV_BY_8 & ~wr_wctrl & ~smr
        |=> ~word_tick [*7] ##1 word_tick)
        else $error("divide by eight spacing wrong");
    recover_keep_a: assert property (smr |=> byte_cfg_q[4:1] == $past(byte_cfg_q[4:1])
        && shared_q[5:4] == $past(shared_q[5:4]) && bstate_q == BC_IDLE)
        else $error("stop recovery lost kept fields");
    byte_load_a: assert property (byte_start_s |=> byte_loaded_s)
        else $error("byte counter start load wrong");
    byte_single_a: assert property (byte_term & (bstate_q == BC_RUN) & byte_cfg_q[BIT_SINGLE] & ~wr_bctrl & ~smr
        |=> bflag_q && bstate_q == BC_IDLE ##1 byte_irq_q == byte_cfg_q[BIT_TOUT_IE])
        else $error("single pass byte timeout wrong");
    first_half_a: assert property (byte_term & (bstate_q == BC_FIRST) & ~bflag_q & ~wr_bctrl & ~smr
        |=> ~bflag_q && bstate_q == BC_RUN && bout_q != $past(bout_q))
        else $error("first half period flagged or not toggled");
    byte_cycle_a: assert property (byte_term & (bstate_q == BC_RUN) & ~byte_cfg_q[BIT_SINGLE] & ~wr_bctrl & ~smr
        |=> bflag_q && bcnt_q == ($past(bout_q) ? $past(blo_q) : $past(bhi_q)))
        else $error("repeating byte reload wrong");
    byte_wrap_a: assert property ((bstate_q != BC_IDLE) & byte_tick & bcnt_q == 8'h00 & ~wr_bctrl & ~smr
        |=> bcnt_q == 8'hFF)
        else $error("byte count zero did not wrap");
    idle_level_a: assert property (~wrun_q & ~frc[1] |-> word_level == ~shared_q[BIT_WORD_INIT])
        else $error("idle word output level wrong");
    force_level_a: assert property (frc == FORCE_HIGH |=> word_level || frc != FORCE_HIGH)
        else $error("forced word level not high");
    flag_clear_a: assert property (wr_wctrl & wd[BIT_TOUT] & ~word_set |=> ~wflag_q)
        else $error("word flag not cleared");
    flag_set_a: assert property (word_set |=> wflag_q)
        else $error("word flag lost against clear");
    word_hold_a: assert property (~wrun_q & ~wr_wctrl & ~smr |=> $stable(wcnt_q))
        else $error("stopped word counter moved");
    bus_answer_a: assert property (req & wait_q |=> ~wait_q ##1 wait_q)
        else $error("bus answer timing wrong");

endmodule

// >>> verif/dirt_pin_model.sv
`timescale 1ns/100ps
module dirt_pin_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        meas_en_i,
    input  wire logic        pin_i,
    output wire logic        demod_a_o,
    output wire logic        demod_b_o,
    output logic             seg_done_o,
    output logic [15:0]      seg_len_o
);
    logic [15:0] len_q;
    logic        last_q;
    logic        armed_q;
    logic [3:0]  wave_q;

    // Slow pattern so the demodulator inputs never sit still
    assign demod_a_o = wave_q[3];
    assign demod_b_o = ~wave_q[2];

    // ==========================================
    // Level-width meter; the first edge only arms it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            len_q      <= 16'h0001;
            last_q     <= 1'b0;
            armed_q    <= 1'b0;
            wave_q     <= 4'h0;
            seg_done_o <= 1'b0;
            seg_len_o  <= 16'h0000;
        end else begin
            wave_q     <= wave_q + 4'h1;
            last_q     <= pin_i;
            seg_done_o <= 1'b0;
            if (!meas_en_i) begin
                armed_q <= 1'b0;
                len_q   <= 16'h0001;
            end else if (pin_i !== last_q) begin
                armed_q    <= 1'b1;
                len_q      <= 16'h0001;
                seg_done_o <= armed_q;
                seg_len_o  <= len_q;
            end else begin
                len_q <= len_q + 16'h0001;
            end
        end
    end
endmodule

// >>> verif/dirt_timer_bench.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
module dirt_timer_bench;
    import dirt_pkg::*;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic        stop_rec = 1'b0;
    logic        meas_en = 1'b0;
    logic [31:0] lfsr = 32'hFDDC;
    logic [7:0]  lo, hi, sh;
    logic        e;
    logic [31:0] exp_rd;
    logic [15:0] exp_len;
    logic [31:0] rd_exp_q[$];
    logic [15:0] len_exp[$];
    wire  [31:0] rdata;
    wire         wait_r, dm_a, dm_b, pb, pw, ps, ib, iw, seg_done;
    wire  [15:0] seg_len;
    int          fails = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    always #2.5 clk_i = ~clk_i;

    dirt_timer dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
        .stop_recover_i(stop_rec), .demod_input_pin_a_i(dm_a), .demod_input_pin_b_i(dm_b),
        .byte_output_pin_o(pb), .word_output_pin_o(pw), .shared_output_pin_o(ps),
        .byte_timeout_irq_o(ib), .word_timeout_irq_o(iw));
    dirt_pin_model pins (.clk_i(clk_i), .rst_n_i(arst_n_i), .meas_en_i(meas_en), .pin_i(pb),
        .demod_a_o(dm_a), .demod_b_o(dm_b), .seg_done_o(seg_done), .seg_len_o(seg_len));

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // ==========================================
    // Bus master; request held until waitrequest sampled low
    task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_i);
        adr <= a;
        wr  <= w;
        rd  <= !w;
        wd  <= {24'h000000, d};
        do @(posedge clk_i); while (wait_r !== 1'b0);
        rd  <= 1'b0;
        wr  <= 1'b0;
    endtask
    task automatic rd_exp(input logic [5:0] a, input logic [7:0] x);
        rd_exp_q.push_back({24'h000000, x});
        bus(a, 1'b0, 8'h00);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask

    task automatic print_verdict();
        if (fails == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ==========================================
    // Result watchers
    always @(posedge clk_i) begin
        if (rd && wait_r === 1'b0) begin
            exp_rd = rd_exp_q.pop_front();
            `CHK(rdata, exp_rd)
        end
        if (seg_done === 1'b1) begin
            exp_len = len_exp.pop_front();
            `CHK(seg_len, exp_len)
        end
        cycles++;
        if (cycles == 8000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        settle();
        rd_exp(6'h00, CTRL_RST);
        rd_exp(6'h04, SHARED_RST);
        rd_exp(6'h08, CTRL_RST);
        rd_exp(6'h3C, 8'h00);
        // Stopped word counter: idle level, then both force codes
        bus(6'h08, 1'b1, 8'h01);
        for (int i = 0; i < 4; i++) begin
            sh = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'h08 : 8'h0C;
            bus(6'h04, 1'b1, sh);
            settle();
            `CHK(pw, (i == 0 || i == 3))
        end
        // Byte output parked high by a 2048-cycle count
        bus(6'h04, 1'b1, 8'h02);
        bus(6'h10, 1'b1, 8'h00);
        bus(6'h14, 1'b1, 8'h00);
        bus(6'h00, 1'b1, 8'h99);
        rd_exp(6'h00, 8'h99);
        for (int c = 0; c < 4; c++) begin
            for (int w = 0; w < 2; w++) begin
                bus(6'h04, 1'b1, 8'h42 | (8'(c) << 4) | (w ? 8'h0C : 8'h08));
                settle();
                e = (c == 0) ? w[0] : (c == 1) ? 1'b1 : (c == 2) ? 1'b0 : !w[0];
                `CHK(pb, 1'b1)
                `CHK(ps, e)
            end
        end
        // Repeating byte count; never a hold of one
        bus(6'h00, 1'b1, 8'h00);
        bus(6'h04, 1'b1, 8'h00);
        lfsr = nxt(lfsr);
        lo = 8'h02 + {5'h00, lfsr[2:0]};
        hi = 8'h02 + {5'h00, lfsr[5:3]};
        bus(6'h10, 1'b1, lo);
        bus(6'h14, 1'b1, hi);
        len_exp = '{16'(hi), 16'(lo), 16'(hi), 16'(lo)};
        bus(6'h00, 1'b1, 8'h83);
        meas_en <= 1'b1;
        while (len_exp.size() > 0) @(posedge clk_i);
        `CHK(ib, 1'b1)
        meas_en <= 1'b0;
        bus(6'h00, 1'b1, 8'h20);
        settle();
        `CHK(ib, 1'b0)
        // Single-pass byte count from the low hold
        bus(6'h00, 1'b1, 8'hC2);
        repeat (12) @(posedge clk_i);
        rd_exp(6'h00, 8'h62);
        `CHK(ib, 1'b1)
        // Single-pass word count of 1 * 256 + 5
        bus(6'h18, 1'b1, 8'h05);
        bus(6'h1C, 1'b1, 8'h01);
        bus(6'h08, 1'b1, 8'hC3);
        rd_exp(6'h08, 8'hC3);
        repeat (300) @(posedge clk_i);
        rd_exp(6'h08, 8'h63);
        `CHK(iw, 1'b1)
        `CHK(pw, 1'b1)
        bus(6'h08, 1'b1, 8'h43);
        rd_exp(6'h08, 8'h63);
        bus(6'h08, 1'b1, 8'h63);
        rd_exp(6'h08, 8'h43);
        `CHK(iw, 1'b0)
        // Stop-mode recovery keeps only the marked fields
        bus(6'h08, 1'b1, 8'hDF);
        bus(6'h04, 1'b1, 8'h7F);
        @(posedge clk_i);
        stop_rec <= 1'b1;
        @(posedge clk_i);
        stop_rec <= 1'b0;
        rd_exp(6'h08, 8'hDF & CTRL_KEEP);
        rd_exp(6'h04, 8'h7F & SHARED_KEEP);
        // Demodulation: rising edges on the second input restart the word count
        bus(6'h04, 1'b1, 8'hD0);
        bus(6'h08, 1'b1, 8'h82);
        repeat (300) @(posedge clk_i);
        rd_exp(6'h08, 8'h82);
        `CHK(iw, 1'b0)
        `CHK(ps, 1'b0)
        // Edges ignored: count runs out at half clock, flag without stopping
        bus(6'h08, 1'b1, 8'hCA);
        repeat (600) @(posedge clk_i);
        rd_exp(6'h08, 8'hEA);
        `CHK(iw, 1'b1)
        settle();
        print_verdict();
    end
endmodule
